// *** lpmpc_pkg.sv ***
// Shared constants and types for the low-power mode and port controller.
package lpmpc_pkg;
    localparam int CLK_PERIOD_NS = 4;
    localparam int RESET_HOLD_NS = 1000;
    localparam int DISC_PINS = 14;
    localparam int NIB_W = 4;
    localparam int BITNUM_W = 4;
    localparam int WP_NUM = 2;
    localparam int WP_DEN = 8;
    localparam int INSTR_CLKS = 8;
    localparam int IRQ_SRCS = 4;

    localparam logic [7:0] OFF_PIN_FUNC = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_DISC_LATCH = 8'h08;
    localparam logic [7:0] OFF_DISC_PINS = 8'h0c;

    localparam int PF_INT = 0;
    localparam int PF_SCK = 1;
    localparam int PF_SI = 2;
    localparam int PF_W = 3;
    localparam int ST_STATE_LSB = 0;
    localparam int ST_STOP_EXIT = 3;
    localparam int ST_SHORT_RST = 4;

    localparam int PIN_INT = 5;
    localparam int PIN_SCK = 6;
    localparam int PIN_SI = 7;

    localparam logic [PF_W-1:0] PIN_FUNC_RST = 3'h0;
    localparam logic [DISC_PINS-1:0] DISC_LATCH_RST = 14'h3fff;
    localparam logic [31:0] APB_ZERO = 32'h0000_0000;

    typedef enum logic [2:0] {
        PS_ACTIVE = 3'b001,
        PS_STANDBY = 3'b010,
        PS_STOP = 3'b100
    } lpmpc_state_t;
endpackage

// *** lpmpc_top.sv ***
// Low-power mode sequencer with discrete and nibble port control behind an APB slave.
//
// Functional notes
// - Standby stops instruction clock; oscillator, interrupts, timers, serial keep running.
// - Standby keeps every register, flag, RAM word and pin unchanged.
// - Standby ends on reset (full reset) or any pending interrupt request.
// - Interrupt wake resumes at the instruction after the standby instruction.
// - After that instruction, take interrupt if enable flag 1, else hold it pending.
// - Stop halts oscillator, execution, interrupts, counters, serial and comparator.
// - Stop ends only by reset, held at least the oscillator settling time; a shorter reset also ends it here and sets the short-reset flag.
// - After stop, RAM kept; accumulator, B, X, Y, carry, serial data lost.
// - Stop puts pins in high impedance; pull-down high-voltage pins pull low.
// - Halt signal low in stop disables drivers, boost and pull-ups; high keeps pins.
// - Output instruction pulses the addressed nibble port for two-eighths instruction cycle.
// - Without the write pulse, only the pull-up holds the high level.
// - Fourteen discrete pins, each set, cleared and tested by bit number.
// - Pins 5 to 11 are shared; nonexistent discrete bits give invalid data.
// - Nibble ports move four bits; nonexistent writes ignored, reads undefined.
// - Pins 5, 6, 7 in interrupt, clock or serial-in use lose their pull-up.
// - A request is present when its flag is 1 and its mask bit is 0.
module lpmpc_top
    import lpmpc_pkg::*;
#(
    parameter int NIB_PORTS = 3,
    parameter int INSTR_CYCLE_CLKS = lpmpc_pkg::INSTR_CLKS,
    parameter int RESET_HOLD_TIME_NS = lpmpc_pkg::RESET_HOLD_NS,
    parameter logic [lpmpc_pkg::DISC_PINS-1:0] PULLUP_OPT = 14'h0fe0,
    parameter logic [lpmpc_pkg::DISC_PINS-1:0] PULLDOWN_OPT = 14'h0000
) (
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic enter_standby_instr_in,
    input wire logic stop_instr_in,
    input wire logic instr_done_in,
    input wire logic [lpmpc_pkg::IRQ_SRCS-1:0] irq_flag_in,
    input wire logic [lpmpc_pkg::IRQ_SRCS-1:0] irq_mask_bit_in,
    input wire logic interrupt_enable_flag_in,
    input wire logic discrete_bit_set_clear_instr_in,
    input wire logic discrete_bit_set_value_in,
    input wire logic discrete_bit_test_instr_in,
    input wire logic [lpmpc_pkg::BITNUM_W-1:0] discrete_bitnum_in,
    input wire logic acc_to_nibble_port_in,
    input wire logic nibble_port_to_acc_in,
    input wire logic [3:0] nibble_port_addr_in,
    input wire logic [lpmpc_pkg::NIB_W-1:0] nibble_wdata_in,
    input wire logic [lpmpc_pkg::DISC_PINS-1:0] disc_pin_in,
    input wire logic [NIB_PORTS*lpmpc_pkg::NIB_W-1:0] nib_pin_in,
    output logic [lpmpc_pkg::DISC_PINS-1:0] disc_pin_out,
    output logic [lpmpc_pkg::DISC_PINS-1:0] disc_pin_oe_out,
    output logic [lpmpc_pkg::DISC_PINS-1:0] disc_pullup_en_out,
    output logic [lpmpc_pkg::DISC_PINS-1:0] disc_pulldown_en_out,
    output logic [NIB_PORTS*lpmpc_pkg::NIB_W-1:0] nib_pin_out,
    output logic [NIB_PORTS*lpmpc_pkg::NIB_W-1:0] nib_pin_oe_out,
    output logic [NIB_PORTS-1:0] nib_write_pulse_out,
    output logic discrete_bit_test_out,
    output logic discrete_bit_valid_out,
    output logic [lpmpc_pkg::NIB_W-1:0] nibble_rdata_out,
    output logic exec_clk_en_out,
    output logic osc_en_out,
    output logic periph_en_out,
    output logic comp_en_out,
    output logic halt_n_out,
    output logic take_irq_out,
    output logic core_regs_lost_out,
    output lpmpc_pkg::lpmpc_state_t power_state_out
);
    import lpmpc_pkg::*;

    localparam int NW = NIB_PORTS * NIB_W;
    localparam int RST_HOLD_CLKS = (RESET_HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WP_CLKS = (INSTR_CYCLE_CLKS * WP_NUM) / WP_DEN < 1 ? 1 :
                             (INSTR_CYCLE_CLKS * WP_NUM) / WP_DEN;
    localparam int RC_W = $clog2(RST_HOLD_CLKS + 1);
    localparam int WC_W = $clog2(WP_CLKS + 1);

    function automatic logic apb_hit(input logic [7:0] a, input logic [7:0] off);
        apb_hit = (a == off);
    endfunction

    lpmpc_state_t state_ff, nxt_state;
    logic irq_present;
    logic wake_pending_ff;
    logic [DISC_PINS-1:0] disc_s1_ff, disc_s2_ff;
    logic [NW-1:0] nib_s1_ff, nib_s2_ff;
    logic [DISC_PINS-1:0] disc_latch_ff;
    logic [NW-1:0] nib_latch_ff;
    logic [PF_W-1:0] pin_func_ff;
    logic stop_exit_ff, short_rst_ff;
    logic [RC_W-1:0] rst_cnt_ff;
    logic [WC_W-1:0] wp_cnt_ff [NIB_PORTS];
    logic [DISC_PINS-1:0] func_input;
    logic executing;
    logic apb_acc, apb_wr, apb_rd_hit;
    logic [31:0] rd_mux;
    logic [RC_W-1:0] rst_hold_min;

    assign rst_hold_min = RC_W'(RST_HOLD_CLKS);
    assign irq_present = |(irq_flag_in & ~irq_mask_bit_in);
    assign executing = (state_ff == PS_ACTIVE);

    // Pins 5 to 7 switched to their input function lose the pull-up and the driver.
    always_comb begin
        func_input = '0;
        func_input[PIN_INT] = pin_func_ff[PF_INT];
        func_input[PIN_SCK] = pin_func_ff[PF_SCK];
        func_input[PIN_SI] = pin_func_ff[PF_SI];
    end

    // Power state; reset is the only way out of stop.
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            PS_ACTIVE: begin
                if (stop_instr_in) begin
                    nxt_state = PS_STOP;
                end else if (enter_standby_instr_in) begin
                    nxt_state = PS_STANDBY;
                end
            end
            PS_STANDBY: begin
                if (irq_present) begin
                    nxt_state = PS_ACTIVE;
                end
            end
            PS_STOP: begin
                nxt_state = PS_STOP;
            end
            default: begin
                nxt_state = PS_ACTIVE;
            end
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            state_ff <= PS_ACTIVE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Mode outputs follow the next state so the core gates off in the entry cycle.
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            exec_clk_en_out <= 1'b1;
            osc_en_out <= 1'b1;
            periph_en_out <= 1'b1;
            comp_en_out <= 1'b1;
            halt_n_out <= 1'b1;
            power_state_out <= PS_ACTIVE;
        end else begin
            exec_clk_en_out <= (nxt_state == PS_ACTIVE);
            osc_en_out <= (nxt_state != PS_STOP);
            periph_en_out <= (nxt_state != PS_STOP);
            comp_en_out <= (nxt_state == PS_ACTIVE);
            halt_n_out <= (nxt_state != PS_STOP);
            power_state_out <= nxt_state;
        end
    end

    // After an interrupt wake the next instruction runs first, then the request is judged.
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            wake_pending_ff <= 1'b0;
            take_irq_out <= 1'b0;
        end else begin
            take_irq_out <= 1'b0;
            if (state_ff == PS_STANDBY && irq_present) begin
                wake_pending_ff <= 1'b1;
            end else if (wake_pending_ff && instr_done_in) begin
                wake_pending_ff <= 1'b0;
                take_irq_out <= interrupt_enable_flag_in && irq_present;
            end
        end
    end

    // Reset width and stop-exit tracking; these flops deliberately see the reset as data.
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            if (rst_cnt_ff != rst_hold_min) begin
                rst_cnt_ff <= rst_cnt_ff + RC_W'(1);
            end
            if (state_ff == PS_STOP) begin
                stop_exit_ff <= 1'b1;
                core_regs_lost_out <= 1'b1;
            end else if (core_regs_lost_out) begin
                core_regs_lost_out <= 1'b1;
            end else begin
                // A reset that did not start in stop is ordinary and clears the record.
                stop_exit_ff <= 1'b0;
                core_regs_lost_out <= 1'b0;
            end
        end else begin
            rst_cnt_ff <= '0;
            core_regs_lost_out <= 1'b0;
            if (apb_wr && apb_hit(paddr_in, OFF_STATUS) && pwdata_in[ST_STOP_EXIT]) begin
                stop_exit_ff <= 1'b0;
            end
        end
    end

    // A reset that leaves stop shorter than the settling time is flagged for software.
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            short_rst_ff <= 1'b0;
        end else if (stop_exit_ff && rst_cnt_ff != '0 && rst_cnt_ff < rst_hold_min) begin
            short_rst_ff <= 1'b1;
        end else if (apb_wr && apb_hit(paddr_in, OFF_STATUS) && pwdata_in[ST_SHORT_RST]) begin
            short_rst_ff <= 1'b0;
        end
    end

    always_ff @(posedge clock_in) begin
        disc_s1_ff <= disc_pin_in;
        disc_s2_ff <= disc_s1_ff;
        nib_s1_ff <= nib_pin_in;
        nib_s2_ff <= nib_s1_ff;
    end

    // Port latches only change on executed instructions, so standby retains them.
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            disc_latch_ff <= DISC_LATCH_RST;
            discrete_bit_test_out <= 1'b0;
            discrete_bit_valid_out <= 1'b0;
        end else begin
            discrete_bit_valid_out <= 1'b0;
            if (executing && discrete_bit_set_clear_instr_in &&
                discrete_bitnum_in < BITNUM_W'(DISC_PINS)) begin
                disc_latch_ff[discrete_bitnum_in] <= discrete_bit_set_value_in;
            end
            if (executing && discrete_bit_test_instr_in) begin
                if (discrete_bitnum_in < BITNUM_W'(DISC_PINS)) begin
                    discrete_bit_test_out <= disc_s2_ff[discrete_bitnum_in];
                    discrete_bit_valid_out <= 1'b1;
                end else begin
                    discrete_bit_test_out <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            nib_latch_ff <= '1;
            nibble_rdata_out <= '0;
        end else begin
            if (executing && acc_to_nibble_port_in && nibble_port_addr_in < 4'(NIB_PORTS)) begin
                nib_latch_ff[nibble_port_addr_in*NIB_W +: NIB_W] <= nibble_wdata_in;
            end
            if (executing && nibble_port_to_acc_in) begin
                nibble_rdata_out <= (nibble_port_addr_in < 4'(NIB_PORTS)) ?
                    nib_s2_ff[nibble_port_addr_in*NIB_W +: NIB_W] : '0;
            end
        end
    end

    // Boost pulse per nibble port; the pull-up alone holds the high level afterwards.
    genvar gi;
    generate
        for (gi = 0; gi < NIB_PORTS; gi++) begin : g_wp
            always_ff @(posedge clock_in) begin
                if (sys_rst_in) begin
                    wp_cnt_ff[gi] <= '0;
                    nib_write_pulse_out[gi] <= 1'b0;
                end else if (executing && acc_to_nibble_port_in &&
                             nibble_port_addr_in == 4'(gi)) begin
                    wp_cnt_ff[gi] <= WC_W'(WP_CLKS - 1);
                    nib_write_pulse_out[gi] <= 1'b1;
                end else if (wp_cnt_ff[gi] != '0) begin
                    wp_cnt_ff[gi] <= wp_cnt_ff[gi] - WC_W'(1);
                end else begin
                    nib_write_pulse_out[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // Pin drive; in stop every driver and pull-up is off and only pull-downs remain.
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            disc_pin_out <= DISC_LATCH_RST;
            disc_pin_oe_out <= '0;
            disc_pullup_en_out <= PULLUP_OPT;
            disc_pulldown_en_out <= PULLDOWN_OPT;
            nib_pin_out <= '1;
            nib_pin_oe_out <= '0;
        end else begin
            disc_pin_out <= disc_latch_ff;
            nib_pin_out <= nib_latch_ff;
            disc_pulldown_en_out <= PULLDOWN_OPT;
            if (nxt_state == PS_STOP) begin
                disc_pin_oe_out <= '0;
                disc_pullup_en_out <= '0;
                nib_pin_oe_out <= '0;
            end else begin
                // Open-drain style: drive only a low; plain input use relies on the latch at 1, function inputs are gated off.
                disc_pin_oe_out <= ~disc_latch_ff & ~func_input;
                disc_pullup_en_out <= PULLUP_OPT & ~func_input;
                nib_pin_oe_out <= ~nib_latch_ff;
            end
        end
    end

    // APB slave: one wait state, then pready with registered data.
    assign apb_acc = psel_in && penable_in && pready_out;
    assign apb_wr = apb_acc && pwrite_in;
    assign apb_rd_hit = apb_hit(paddr_in, OFF_PIN_FUNC) || apb_hit(paddr_in, OFF_STATUS) ||
                        apb_hit(paddr_in, OFF_DISC_LATCH) || apb_hit(paddr_in, OFF_DISC_PINS);

    always_comb begin
        rd_mux = APB_ZERO;
        if (apb_hit(paddr_in, OFF_PIN_FUNC)) begin
            rd_mux[PF_W-1:0] = pin_func_ff;
        end else if (apb_hit(paddr_in, OFF_STATUS)) begin
            rd_mux[ST_STATE_LSB +: 3] = state_ff;
            rd_mux[ST_STOP_EXIT] = stop_exit_ff;
            rd_mux[ST_SHORT_RST] = short_rst_ff;
        end else if (apb_hit(paddr_in, OFF_DISC_LATCH)) begin
            rd_mux[DISC_PINS-1:0] = disc_latch_ff;
        end else if (apb_hit(paddr_in, OFF_DISC_PINS)) begin
            rd_mux[DISC_PINS-1:0] = disc_s2_ff;
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= APB_ZERO;
        end else begin
            pready_out <= psel_in && penable_in && !pready_out;
            pslverr_out <= psel_in && penable_in && !pready_out && !apb_rd_hit;
            prdata_out <= (psel_in && penable_in && !pready_out && !pwrite_in) ? rd_mux : APB_ZERO;
        end
    end

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            pin_func_ff <= PIN_FUNC_RST;
        end else if (apb_wr && apb_hit(paddr_in, OFF_PIN_FUNC)) begin
            pin_func_ff <= pwdata_in[PF_W-1:0];
        end
    end

    standby_hold_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        state_ff == PS_STANDBY |=> $stable(disc_latch_ff) && $stable(nib_latch_ff))
        else $error("Port latch changed in standby.");
    standby_exec_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        state_ff == PS_STANDBY && !irq_present |=> !exec_clk_en_out && osc_en_out && periph_en_out)
        else $error("Standby clock gating wrong.");
    standby_wake_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        state_ff == PS_STANDBY && irq_present |=> state_ff == PS_ACTIVE && exec_clk_en_out)
        else $error("Interrupt did not end standby.");
    stop_sticky_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        state_ff == PS_STOP |=> state_ff == PS_STOP)
        else $error("Stop left without reset.");
    stop_halt_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        state_ff == PS_STOP |-> !halt_n_out && !osc_en_out && !comp_en_out)
        else $error("Halt or oscillator active in stop.");
    stop_hiz_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        state_ff == PS_STOP |-> disc_pin_oe_out == '0 && disc_pullup_en_out == '0
        && nib_pin_oe_out == '0)
        else $error("Pin driven in stop.");
    irq_take_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        wake_pending_ff && instr_done_in && !interrupt_enable_flag_in |=> !take_irq_out)
        else $error("Interrupt taken with enable flag clear.");
    pullup_off_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        pin_func_ff[PF_SI] && state_ff != PS_STOP |=> !disc_pullup_en_out[PIN_SI])
        else $error("Serial input pin pull-up left on.");
    wpulse_len_a: assert property (@(posedge clock_in) disable iff (sys_rst_in)
        executing && acc_to_nibble_port_in && nibble_port_addr_in == 4'h0
        |=> nib_write_pulse_out[0] [*2])
        else $error("Write pulse too short.");
    reset_active_a: assert property (@(posedge clock_in)
        sys_rst_in |=> state_ff == PS_ACTIVE && halt_n_out)
        else $error("Reset did not return to active.");
endmodule

// *** lpmpc_pins_model.sv ***
// Board model: the reset source and the pin levels seen by the controller.
module lpmpc_pins_model #(
    parameter int NP = 3
) (
    input wire logic clock_in,
    output logic sys_rst_out,
    input wire logic [13:0] d_out_in,
    input wire logic [13:0] d_oe_in,
    input wire logic [13:0] d_pu_in,
    input wire logic [13:0] d_pd_in,
    input wire logic [NP*4-1:0] r_out_in,
    input wire logic [NP*4-1:0] r_oe_in,
    output logic [13:0] d_pin_out,
    output logic [NP*4-1:0] r_pin_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sys_rst_out = 1'h1;
        d_pin_out = '0;
        r_pin_out = '1;
    end
    // An undriven line without any pull toggles, so a stale level is never mistaken for data.
    always @(posedge clock_in) begin
        for (int i = 0; i < 14; i++) begin
            d_pin_out[i] <= d_oe_in[i] ? d_out_in[i] : d_pu_in[i] ? 1'h1 :
                d_pd_in[i] ? 1'h0 : ~d_pin_out[i];
        end
        // Board resistors pull every nibble line high.
        r_pin_out <= (r_oe_in & r_out_in) | ~r_oe_in;
    end
    // The caller chooses the hold count; a count under the settling time still leaves stop but sets the short-reset flag.
    task hold_reset(input int n);
        sys_rst_out <= 1'h1;
        repeat (n) @(posedge clock_in);
        sys_rst_out <= 1'h0;
    endtask
endmodule

// *** lpmpc_top_tb.sv ***
// Self-checking bench for the low-power mode and port controller.
module lpmpc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import lpmpc_pkg::*;
    localparam logic [13:0] PD = 14'h001f;
    localparam int HOLD = 10;
    localparam logic [5:0] ROWS [6] = '{6'h20, 6'h23, 6'h2c, 6'h2f, 6'h00, 6'h27};
    logic clock_in, sys_rst_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
    logic [7:0] paddr_in;
    logic [31:0] pwdata_in, prdata_out, rd;
    logic [6:0] stb;
    logic enter_standby_instr_in, stop_instr_in, instr_done_in, discrete_bit_set_clear_instr_in;
    logic discrete_bit_test_instr_in, acc_to_nibble_port_in, nibble_port_to_acc_in, er;
    logic interrupt_enable_flag_in, discrete_bit_set_value_in, discrete_bit_test_out;
    logic discrete_bit_valid_out, exec_clk_en_out, osc_en_out, periph_en_out, comp_en_out;
    logic halt_n_out, take_irq_out, core_regs_lost_out;
    logic [3:0] irq_flag_in, irq_mask_bit_in, discrete_bitnum_in, nibble_port_addr_in;
    logic [3:0] nibble_wdata_in, nibble_rdata_out;
    logic [13:0] disc_pin_in, disc_pin_out, disc_pin_oe_out, disc_pullup_en_out, keep;
    logic [13:0] disc_pulldown_en_out;
    logic [11:0] nib_pin_in, nib_pin_out, nib_pin_oe_out;
    logic [2:0] nib_write_pulse_out;
    lpmpc_state_t power_state_out;
    int miscompares = 0;
    int n_compared = 0;
    assign {nibble_port_to_acc_in, acc_to_nibble_port_in, discrete_bit_test_instr_in,
        discrete_bit_set_clear_instr_in, instr_done_in, stop_instr_in,
        enter_standby_instr_in} = stb;

    lpmpc_top #(.RESET_HOLD_TIME_NS(40), .PULLDOWN_OPT(PD)) lpmpc_top_inst (.*);

    lpmpc_pins_model lpmpc_pins_model_inst (
        .clock_in(clock_in), .sys_rst_out(sys_rst_in), .d_out_in(disc_pin_out),
        .d_oe_in(disc_pin_oe_out), .d_pu_in(disc_pullup_en_out),
        .d_pd_in(disc_pulldown_en_out), .r_out_in(nib_pin_out), .r_oe_in(nib_pin_oe_out),
        .d_pin_out(disc_pin_in), .r_pin_out(nib_pin_in)
    );

    initial begin
        clock_in = 1'h0;
        forever #2 clock_in = ~clock_in;
    end

    task chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL at %0t: %s", $time, what);
        end
    endtask

    task conclude();
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task cyc(input int n);
        repeat (n) @(negedge clock_in);
    endtask

    task pulse(input int i);
        @(posedge clock_in);
        stb[i] <= 1'h1;
        @(posedge clock_in);
        stb[i] <= 1'h0;
        @(negedge clock_in);
    endtask

    task rst(input int n);
        @(posedge clock_in);
        lpmpc_pins_model_inst.hold_reset(n);
    endtask

    // The request stays up until pready is seen high at a rising edge.
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_in);
        psel_in <= 1'h1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clock_in);
        penable_in <= 1'h1;
        do @(posedge clock_in); while (pready_out !== 1'h1);
        rd = prdata_out;
        er = pslverr_out;
        psel_in <= 1'h0;
        penable_in <= 1'h0;
    endtask

    task disc(input logic [3:0] b, input logic v);
        @(posedge clock_in);
        discrete_bitnum_in <= b;
        discrete_bit_set_value_in <= v;
        pulse(3);
        cyc(6);
        pulse(4);
    endtask

    task nib(input logic [3:0] a, input logic [3:0] d, input logic [2:0] w, input logic [3:0] r);
        @(posedge clock_in);
        nibble_port_addr_in <= a;
        nibble_wdata_in <= d;
        pulse(5);
        chk(nib_write_pulse_out, w, "write pulse on");
        cyc(1);
        chk(nib_write_pulse_out, w, "write pulse held");
        cyc(1);
        chk(nib_write_pulse_out, 3'h0, "write pulse off");
        chk(nib_pin_oe_out, 12'h005, "nibble drive");
        cyc(4);
        pulse(6);
        chk(nibble_rdata_out, r, "nibble read");
    endtask

    initial begin
        repeat (5000) @(posedge clock_in);
        miscompares++;
        conclude();
    end

    initial begin
        {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in, stb, irq_flag_in} = '0;
        {discrete_bit_set_value_in, discrete_bitnum_in, nibble_port_addr_in} = '0;
        {interrupt_enable_flag_in, nibble_wdata_in} = '0;
        irq_mask_bit_in = 4'hf;
        lpmpc_pins_model_inst.hold_reset(2);
        cyc(1);
        chk(power_state_out, PS_ACTIVE, "state after reset");
        chk({halt_n_out, disc_pin_oe_out}, 15'h4000, "pins after reset");
        chk({disc_pullup_en_out, disc_pulldown_en_out}, {14'h0fe0, PD}, "pulls after reset");
        apb(1'h0, OFF_PIN_FUNC, APB_ZERO);
        chk(rd, APB_ZERO, "pin function reset");
        apb(1'h0, OFF_STATUS, APB_ZERO);
        chk(rd[4:0], 5'h01, "status reset");
        apb(1'h0, 8'h10, APB_ZERO);
        chk({er, rd}, {1'h1, APB_ZERO}, "unmapped refused");
        $display("test reset done");
        foreach (ROWS[k]) begin
            disc(ROWS[k][5:2], ROWS[k][1]);
            chk({discrete_bit_valid_out, discrete_bit_test_out}, {1'h1, ROWS[k][0]}, "bit test");
        end
        disc(4'he, 1'h0);
        chk({discrete_bit_valid_out, discrete_bit_test_out}, 2'h0, "missing bit");
        chk(disc_pin_oe_out, 14'h0001, "latch after bit ops");
        nib(4'h0, 4'ha, 3'h1, 4'ha);
        nib(4'h3, 4'h0, 3'h0, 4'h0);
        $display("test ports done");
        for (int k = 1; k >= 0; k--) begin
            @(posedge clock_in);
            irq_flag_in <= 4'h2;
            irq_mask_bit_in <= 4'hf;
            interrupt_enable_flag_in <= k[0];
            discrete_bitnum_in <= 4'h9;
            keep = disc_pin_oe_out;
            pulse(0);
            chk(power_state_out, PS_STANDBY, "standby entered");
            chk({exec_clk_en_out, osc_en_out, periph_en_out, comp_en_out}, 4'h6, "clocks");
            pulse(3);
            cyc(3);
            chk(power_state_out, PS_STANDBY, "masked request ignored");
            chk(disc_pin_oe_out, keep, "pins kept in standby");
            @(posedge clock_in);
            irq_mask_bit_in <= 4'hd;
            cyc(1);
            chk(power_state_out, PS_STANDBY, "wake too early");
            cyc(1);
            chk(power_state_out, PS_ACTIVE, "woken by request");
            chk({exec_clk_en_out, take_irq_out}, 2'h2, "resume before taking");
            pulse(2);
            chk(take_irq_out, k[0], "interrupt after next instruction");
        end
        @(posedge clock_in);
        irq_mask_bit_in <= 4'hf;
        pulse(0);
        rst(2);
        cyc(1);
        chk(power_state_out, PS_ACTIVE, "standby left by reset");
        $display("test standby done");
        apb(1'h1, OFF_PIN_FUNC, 32'h0000_0007);
        apb(1'h0, OFF_PIN_FUNC, APB_ZERO);
        chk(rd, 32'h0000_0007, "pin function readback");
        chk(disc_pullup_en_out, 14'h0f00, "shared pins lose pull-up");
        @(posedge clock_in);
        irq_mask_bit_in <= 4'hd;
        pulse(1);
        chk(power_state_out, PS_STOP, "stop entered");
        chk({osc_en_out, exec_clk_en_out, periph_en_out, comp_en_out, halt_n_out}, 5'h00,
            "stop halts all");
        chk({nib_pin_oe_out, disc_pin_oe_out, disc_pullup_en_out}, '0, "pins released");
        chk(disc_pulldown_en_out, PD, "pull-downs kept");
        pulse(0);
        cyc(4);
        chk(power_state_out, PS_STOP, "only reset leaves stop");
        fork
            rst(HOLD);
            begin
                cyc(5);
                chk(core_regs_lost_out, 1'h1, "core registers lost");
            end
        join
        cyc(1);
        chk(power_state_out, PS_ACTIVE, "stop left by reset");
        chk(disc_pullup_en_out, 14'h0fe0, "pin functions reset");
        apb(1'h0, OFF_STATUS, APB_ZERO);
        chk(rd[4:0], 5'h09, "stop exit recorded");
        pulse(1);
        rst(4);
        cyc(1);
        apb(1'h0, OFF_STATUS, APB_ZERO);
        chk(rd[4:0], 5'h19, "short stop reset flagged");
        apb(1'h1, OFF_STATUS, 32'h0000_0018);
        apb(1'h0, OFF_STATUS, APB_ZERO);
        chk(rd[4:0], 5'h01, "status flags cleared");
        $display("test stop done");
        conclude();
    end
endmodule
